//--- hdl/etdd_pkg.sv
// =============================================================
// constants of the event-timed direct transfer engine
package etdd_pkg;
    // register byte addresses
    localparam logic [11:0] ETDD_CTRL = 12'h000;
    localparam logic [11:0] ETDD_BASE = 12'h004;
    localparam logic [11:0] ETDD_NBLK = 12'h008;
    localparam logic [11:0] ETDD_BSTR = 12'h00C;
    localparam logic [11:0] ETDD_KSTR = 12'h010;
    localparam logic [11:0] ETDD_CHEN_LO = 12'h014;
    localparam logic [11:0] ETDD_CHEN_HI = 12'h018;
    localparam logic [11:0] ETDD_STATUS = 12'h01C;
    localparam logic [3:0] ETDD_MAP_PAGE = 4'h1; // map words at 0x100..0x1fc
    // control fields
    localparam int ETDD_RUN_BIT = 0;
    localparam int ETDD_EGRESS_BIT = 1;
    localparam int ETDD_RSA_BIT = 2;
    localparam int ETDD_BUF256_BIT = 3;
    localparam int ETDD_QPC_LSB = 8;
    localparam int ETDD_NCAR_LSB = 12;
    localparam int ETDD_BLEN_LSB = 24;
    localparam logic [31:0] ETDD_CTRL_MASK = 32'h0F07_FF0F;
    localparam logic [31:0] ETDD_CTRL_RST = 32'h0400_0100; // 1 qw, burst 4 qw
    localparam logic [31:0] ETDD_ZERO = 32'h0000_0000;
    // address unit of the strides is 0x10 bytes
    localparam int ETDD_QW_SHIFT = 4;
    localparam logic [3:0] ETDD_MASK_128 = 4'h7; // 8 qw circular region
    localparam logic [3:0] ETDD_MASK_256 = 4'hF; // 16 qw circular region
    localparam logic [1:0] ETDD_OKAY = 2'h0;
    localparam logic [1:0] ETDD_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_CHECK, ST_MOVE} etdd_state_e;
endpackage

//--- hdl/etdd_map_ram.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// channel map: 64 slots, one write port, two registered read ports
module etdd_map_ram
    import etdd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire logic [5:0] wdata,
    input wire logic [5:0] raddr_a,
    output logic [5:0] rdata_a,
    input wire logic [5:0] raddr_b,
    output logic [5:0] rdata_b
);
    logic [5:0] mem [64];

    // storage, cleared by reset so reads are defined
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 64; i++) begin
                mem[i] <= 6'h00;
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read ports
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_a <= 6'h00;
            rdata_b <= 6'h00;
        end else begin
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end
endmodule // etdd_map_ram
`default_nettype wire

//--- hdl/etdd_engine.sv
// Behaviour
// - each carrier moves a programmed count of quadwords per event
// - each event serves the programmed count of carrier slots
// - base address is bus source (egress) or destination (ingress), start point
// - burst length setting caps quadwords per bus burst
// - only enabled channels move data
// - egress data-type bit selects downlink or uplink processed data
// - after the programmed block count the address returns to base
// - after each burst the address steps by burst stride times 0x10
// - after each block the address steps by block stride times 0x10
// - sixty-four map entries assign slots in order to buffer channels
// - strides apply only to the bus-side address
// - events come every eight or four chips via the iteration strobe
// - running configuration changes apply at the next frame boundary, except the run bit, which gates new events at once, and map writes at once
// - changed configuration registers held as a pair, switched at frame boundary while running, at once when stopped
// - frame strobe restarts the sequence, iteration strobe starts a block
// - each carrier buffer region is 128 or 256 bytes
// - this engine wins the bus over packet transfer requests
`timescale 1ns/1ps
`default_nettype none
module etdd_engine
    import etdd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_strobe,
    input wire logic iter_strobe,
    output logic dma_valid,
    input wire logic dma_ready,
    output logic [31:0] dma_addr,
    output logic dma_burst_start,
    output logic dma_egress,
    output logic dma_rsa,
    output logic [5:0] dma_channel,
    output logic [3:0] dma_db_qw,
    input wire logic pkt_valid,
    output logic pkt_grant
);
    // =============================================================
    // helpers
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[8*i +: 8] = d[8*i +: 8];
        end
        return r;
    endfunction

    // true when cnt is the last step of a count of lim (zero counts as one)
    function automatic logic is_last(input logic [15:0] cnt, input logic [15:0] lim);
        return (lim == 16'h0000) || (cnt >= lim - 16'h0001);
    endfunction

    function automatic logic [31:0] stride(input logic [15:0] s);
        return {12'h000, s, 4'h0};
    endfunction

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // =============================================================
    // register bus slave
    logic aw_have_q, w_have_q, rd_pend_q, do_write, cfg_wr, map_we, swap, pend_q;
    logic [11:0] aw_addr_q, rd_addr_q;
    logic [31:0] wdata_q, rd_mux;
    logic [3:0] wstrb_q;
    logic [5:0] map_rd_a, map_rd_b, slot_q;
    logic [31:0] sh_ctrl_q, sh_base_q, act_ctrl_q, act_base_q;
    logic [15:0] sh_nblk_q, sh_bstr_q, sh_kstr_q, act_nblk_q, act_bstr_q, act_kstr_q;
    logic [63:0] sh_en_q, act_en_q;
    logic [15:0] blk_cnt_q;
    etdd_state_e st_q;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !rd_pend_q && !s_axi_rvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign cfg_wr = do_write && (aw_addr_q <= ETDD_CHEN_HI);
    assign map_we = do_write && (aw_addr_q[11:8] == ETDD_MAP_PAGE);

    // write address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
            wdata_q <= ETDD_ZERO;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // write response, unmapped or status writes answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ETDD_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (cfg_wr || map_we) ? ETDD_OKAY : ETDD_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // shadow copy written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_ctrl_q <= ETDD_CTRL_RST;
            sh_base_q <= ETDD_ZERO;
            sh_nblk_q <= 16'h0000;
            sh_bstr_q <= 16'h0000;
            sh_kstr_q <= 16'h0000;
            sh_en_q <= 64'h0000_0000_0000_0000;
        end else if (cfg_wr) begin
            unique case (aw_addr_q)
                ETDD_CTRL: sh_ctrl_q <= wmerge(sh_ctrl_q, wdata_q, wstrb_q) & ETDD_CTRL_MASK;
                ETDD_BASE: sh_base_q <= wmerge(sh_base_q, wdata_q, wstrb_q);
                ETDD_NBLK: sh_nblk_q <= 16'(wmerge({16'h0000, sh_nblk_q}, wdata_q, wstrb_q));
                ETDD_BSTR: sh_bstr_q <= 16'(wmerge({16'h0000, sh_bstr_q}, wdata_q, wstrb_q));
                ETDD_KSTR: sh_kstr_q <= 16'(wmerge({16'h0000, sh_kstr_q}, wdata_q, wstrb_q));
                ETDD_CHEN_LO: sh_en_q[31:0] <= wmerge(sh_en_q[31:0], wdata_q, wstrb_q);
                default: sh_en_q[63:32] <= wmerge(sh_en_q[63:32], wdata_q, wstrb_q);
            endcase
        end
    end

    // pending change flag, a new write wins over the swap
    // a stopped engine takes the shadow at once, a running one waits for the frame
    assign swap = pend_q && (frame_strobe || !act_ctrl_q[ETDD_RUN_BIT]);
    always_ff @(posedge aclk) begin
        if (!aresetn) pend_q <= 1'b0;
        else if (cfg_wr) pend_q <= 1'b1;
        else if (swap) pend_q <= 1'b0;
    end

    // active copy, replaced only at a frame boundary while running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_ctrl_q <= ETDD_CTRL_RST;
            act_base_q <= ETDD_ZERO;
            act_nblk_q <= 16'h0000;
            act_bstr_q <= 16'h0000;
            act_kstr_q <= 16'h0000;
            act_en_q <= 64'h0000_0000_0000_0000;
        end else if (swap) begin
            act_ctrl_q <= sh_ctrl_q;
            act_base_q <= sh_base_q;
            act_nblk_q <= sh_nblk_q;
            act_bstr_q <= sh_bstr_q;
            act_kstr_q <= sh_kstr_q;
            act_en_q <= sh_en_q;
        end
    end

    swap_take_a: assert property (swap |=> act_base_q == $past(sh_base_q)
        && act_nblk_q == $past(sh_nblk_q)) else $error("configuration not switched");
    swap_hold_a: assert property (act_ctrl_q[ETDD_RUN_BIT] && !frame_strobe
        |=> $stable(act_ctrl_q) && $stable(act_base_q)) else $error("config changed mid frame");

    // read data mux
    always_comb begin
        unique case (rd_addr_q)
            ETDD_CTRL: rd_mux = sh_ctrl_q;
            ETDD_BASE: rd_mux = sh_base_q;
            ETDD_NBLK: rd_mux = {16'h0000, sh_nblk_q};
            ETDD_BSTR: rd_mux = {16'h0000, sh_bstr_q};
            ETDD_KSTR: rd_mux = {16'h0000, sh_kstr_q};
            ETDD_CHEN_LO: rd_mux = sh_en_q[31:0];
            ETDD_CHEN_HI: rd_mux = sh_en_q[63:32];
            ETDD_STATUS: rd_mux = {blk_cnt_q, 2'b00, slot_q, 6'h00, pend_q, st_q != ST_IDLE};
            default: rd_mux = (rd_addr_q[11:8] == ETDD_MAP_PAGE) ? {26'h000_0000, map_rd_b}
                                                                 : ETDD_ZERO;
        endcase
    end

    // read channel, data one cycle after address taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= 12'h000;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ETDD_ZERO;
            s_axi_rresp <= ETDD_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rd_pend_q <= 1'b1;
                rd_addr_q <= {s_axi_araddr[11:2], 2'b00};
            end else begin
                rd_pend_q <= 1'b0;
            end
            if (rd_pend_q) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (rd_addr_q <= ETDD_STATUS || rd_addr_q[11:8] == ETDD_MAP_PAGE)
                               ? ETDD_OKAY : ETDD_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // channel map storage
    etdd_map_ram u_map (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(map_we),
        .waddr(aw_addr_q[7:2]),
        .wdata(wdata_q[5:0]),
        .raddr_a(slot_q),
        .rdata_a(map_rd_a),
        .raddr_b(s_axi_araddr[7:2]),
        .rdata_b(map_rd_b)
    );

    // =============================================================
    // transfer sequencer
    logic [3:0] qpc, blen, qcnt_q, bcnt_q;
    logic [6:0] ncar;
    logic start, en_hit, acc, adv, ev_end;
    logic [31:0] burst_addr_q, blk_addr_q, base_next;

    assign qpc = act_ctrl_q[ETDD_QPC_LSB +: 4];
    assign ncar = act_ctrl_q[ETDD_NCAR_LSB +: 7];
    assign blen = act_ctrl_q[ETDD_BLEN_LSB +: 4];
    assign base_next = swap ? sh_base_q : act_base_q;
    assign start = iter_strobe && sh_ctrl_q[ETDD_RUN_BIT] && ncar != 7'h00
                   && (st_q == ST_IDLE || frame_strobe);
    assign en_hit = act_en_q[map_rd_a];
    assign acc = st_q == ST_MOVE && dma_ready;
    assign adv = (st_q == ST_CHECK && !en_hit)
                 || (acc && is_last(16'(qcnt_q), 16'(qpc)));
    assign ev_end = adv && is_last(16'(slot_q), 16'(ncar));

    // state: fetch map entry, check enable, move quadwords
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
        end else if (frame_strobe || start) begin
            st_q <= start ? ST_FETCH : ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE: st_q <= ST_IDLE;
                ST_FETCH: st_q <= ST_CHECK;
                ST_CHECK: st_q <= en_hit ? ST_MOVE : (ev_end ? ST_IDLE : ST_FETCH);
                ST_MOVE: if (adv) st_q <= ev_end ? ST_IDLE : ST_FETCH;
            endcase
        end
    end

    // slot and quadword counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_q <= 6'h00;
            qcnt_q <= 4'h0;
        end else if (start) begin
            slot_q <= 6'h00;
            qcnt_q <= 4'h0;
        end else begin
            if (adv && !ev_end) slot_q <= slot_q + 6'h01;
            if (acc) qcnt_q <= is_last(16'(qcnt_q), 16'(qpc)) ? 4'h0 : qcnt_q + 4'h1;
        end
    end

    // burst address, stepped by burst stride when a burst fills
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bcnt_q <= 4'h0;
            burst_addr_q <= ETDD_ZERO;
        end else if (start) begin
            bcnt_q <= 4'h0;
            burst_addr_q <= frame_strobe ? base_next : blk_addr_q;
        end else if (acc) begin
            if (is_last(16'(bcnt_q), 16'(blen))) begin
                bcnt_q <= 4'h0;
                burst_addr_q <= burst_addr_q + stride(act_bstr_q);
            end else begin
                bcnt_q <= bcnt_q + 4'h1;
            end
        end
    end

    // block address, stepped per event and wrapped to base
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blk_cnt_q <= 16'h0000;
            blk_addr_q <= ETDD_ZERO;
        end else if (frame_strobe) begin
            blk_cnt_q <= 16'h0000;
            blk_addr_q <= base_next;
        end else if (ev_end) begin
            if (is_last(blk_cnt_q, act_nblk_q)) begin
                blk_cnt_q <= 16'h0000;
                blk_addr_q <= act_base_q;
            end else begin
                blk_cnt_q <= blk_cnt_q + 16'h0001;
                blk_addr_q <= blk_addr_q + stride(act_kstr_q);
            end
        end
    end

    // transfer request outputs
    assign dma_valid = st_q == ST_MOVE;
    assign dma_addr = burst_addr_q;
    assign dma_burst_start = bcnt_q == 4'h0;
    assign dma_egress = act_ctrl_q[ETDD_EGRESS_BIT];
    assign dma_rsa = act_ctrl_q[ETDD_RSA_BIT];
    assign dma_channel = map_rd_a;
    assign dma_db_qw = 4'(blk_cnt_q[3:0] * qpc + qcnt_q)
                       & (act_ctrl_q[ETDD_BUF256_BIT] ? ETDD_MASK_256 : ETDD_MASK_128);
    assign pkt_grant = pkt_valid && !dma_valid;

    // =============================================================
    // checks
    sequence full_burst_s;
        acc && is_last(16'(bcnt_q), 16'(blen));
    endsequence
    sequence last_block_s;
        ev_end && !frame_strobe && is_last(blk_cnt_q, act_nblk_q);
    endsequence
    sequence mid_block_s;
        ev_end && !frame_strobe && !is_last(blk_cnt_q, act_nblk_q);
    endsequence

    burst_step_a: assert property ((full_burst_s and !start)
        |=> burst_addr_q == $past(burst_addr_q) + stride(act_bstr_q)) else $error("burst step");
    block_wrap_a: assert property (last_block_s
        |=> blk_addr_q == act_base_q && blk_cnt_q == 16'h0000) else $error("no wrap");
    block_step_a: assert property (mid_block_s
        |=> blk_addr_q == $past(blk_addr_q) + stride(act_kstr_q)) else $error("block step");
    pkt_yield_a: assert property (dma_valid |-> !pkt_grant) else $error("packet won");
    ch_enable_a: assert property (dma_valid |-> act_en_q[dma_channel]) else $error("disabled ch");
    qw_bound_a: assert property (dma_valid && qpc != 4'h0 |-> qcnt_q < qpc) else $error("qw count");
    slot_bound_a: assert property (st_q != ST_IDLE |-> 16'(slot_q) < 16'(ncar)) else $error("slot");
    event_start_a: assert property (start && !frame_strobe |=> st_q == ST_FETCH ##1 st_q == ST_CHECK
        && slot_q == 6'h00) else $error("event start");
    burst_len_a: assert property (acc && blen != 4'h0 |-> bcnt_q < blen) else $error("burst len");
endmodule // etdd_engine
`default_nettype wire

//--- sim/etdd_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// far-side bus model: takes quadwords and answers after a set stall
module etdd_bus_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic dma_valid,
    input wire logic [31:0] dma_addr,
    input wire logic dma_burst_start,
    input wire logic dma_egress,
    input wire logic dma_rsa,
    input wire logic [5:0] dma_channel,
    input wire logic [3:0] dma_db_qw,
    input wire logic pkt_grant,
    input wire logic [3:0] stall,
    output logic dma_ready
);
    logic [3:0] wait_q;
    logic [45:0] log_q [0:255];
    int n_q;
    // ready only once the stall count has run out, so slow answers are possible
    assign dma_ready = dma_valid && (wait_q >= stall);
    // each taken quadword is logged with its qualifiers for the bench to judge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_q <= 4'h0;
            n_q <= 0;
        end else if (dma_valid && dma_ready) begin
            wait_q <= 4'h0;
            log_q[n_q[7:0]] <= {dma_addr, dma_channel, dma_db_qw, dma_burst_start,
                                dma_egress, dma_rsa, pkt_grant};
            n_q <= n_q + 1;
        end else if (dma_valid) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule // etdd_bus_partner
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// self-checking bench of the direct transfer engine
module testbench
    import etdd_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic frame_strobe = 1'b0;
    logic iter_strobe = 1'b0;
    logic [3:0] stall = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, dma_valid, dma_ready;
    logic bs, eg, rsa, pkt_grant;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, dma_addr, d;
    logic [5:0] ch;
    logic [3:0] dbq;
    logic [1:0] r;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    etdd_engine i_etdd_engine (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .frame_strobe(frame_strobe), .iter_strobe(iter_strobe),
        .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_addr(dma_addr),
        .dma_burst_start(bs), .dma_egress(eg), .dma_rsa(rsa), .dma_channel(ch),
        .dma_db_qw(dbq), .pkt_valid(1'b1), .pkt_grant(pkt_grant));

    etdd_bus_partner i_etdd_bus_partner (.aclk(aclk), .aresetn(aresetn),
        .dma_valid(dma_valid), .dma_addr(dma_addr), .dma_burst_start(bs),
        .dma_egress(eg), .dma_rsa(rsa), .dma_channel(ch), .dma_db_qw(dbq),
        .pkt_grant(pkt_grant), .stall(stall), .dma_ready(dma_ready));

    // 100 MHz clock
    always #5 aclk = ~aclk;

    // =============================================================
    // reporting
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // cuts a hang short; the whole run needs under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end

    // =============================================================
    // register bus master
    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awready && !ad) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !wd) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        check("bresp", 32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // =============================================================
    // timing events and one block of six quadwords
    task automatic pulse(input bit frame);
        @(posedge aclk);
        if (frame) frame_strobe <= 1'b1;
        else iter_strobe <= 1'b1;
        @(posedge aclk);
        frame_strobe <= 1'b0;
        iter_strobe <= 1'b0;
    endtask

    task automatic run_event(input logic [31:0] ba, input int bc, input logic e,
                             input int m);
        int n0;
        logic [45:0] x;
        n0 = i_etdd_bus_partner.n_q;
        pulse(1'b0);
        for (int t = 0; t < 300 && i_etdd_bus_partner.n_q < n0 + 6; t++) @(posedge aclk);
        repeat (8) @(posedge aclk);
        check("qw count", 32'(i_etdd_bus_partner.n_q - n0), 32'd6);
        for (int i = 0; i < 6; i++) begin
            x = i_etdd_bus_partner.log_q[n0 + i];
            check("addr", x[45:14], ba + 32'((i / 4) * 64));
            check("channel", 32'(x[13:8]), (i < 2) ? 32'd5 : (i < 4) ? 32'd7 : 32'd8);
            check("db qw", 32'(x[7:4]), 32'((bc * 2 + i % 2) % m));
            check("burst start", 32'(x[3]), 32'(i % 4 == 0));
            check("egress", 32'(x[2]), 32'(e));
            check("rsa", 32'(x[1]), 32'(e));
            check("grant busy", 32'(x[0]), 32'd0);
        end
    endtask

    // =============================================================
    // main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(ETDD_CTRL, d, r);
        check("ctrl reset", d, ETDD_CTRL_RST);
        axi_read(12'h020, d, r);
        check("unmapped", 32'(r), 32'(ETDD_SLVERR));
        axi_write(ETDD_STATUS, ETDD_ZERO, ETDD_SLVERR);
        // uplink-style setup: 2 qw, stride 4 qw, block stride 0x80 qw
        axi_write(ETDD_BASE, 32'h0000_1000, ETDD_OKAY);
        axi_write(ETDD_NBLK, 32'h0000_0005, ETDD_OKAY);
        axi_write(ETDD_BSTR, 32'h0000_0004, ETDD_OKAY);
        axi_write(ETDD_KSTR, 32'h0000_0080, ETDD_OKAY);
        axi_write(ETDD_CHEN_LO, 32'h0000_01A0, ETDD_OKAY);
        axi_write(ETDD_CHEN_HI, ETDD_ZERO, ETDD_OKAY);
        for (int i = 0; i < 4; i++) axi_write(12'(12'h100 + 4 * i), 32'(5 + i), ETDD_OKAY);
        pulse(1'b0);
        repeat (10) @(posedge aclk);
        check("stopped", 32'(i_etdd_bus_partner.n_q), 32'd0);
        axi_write(ETDD_CTRL, 32'h0400_4201, ETDD_OKAY);
        pulse(1'b1);
        for (int k = 0; k < 6; k++) begin
            stall <= 4'(k);
            run_event(32'h0000_1000 + 32'(k % 5) * 32'h0000_0800, k % 5, 1'b0, 8);
        end
        check("grant idle", 32'(pkt_grant), 32'd1);
        axi_write(ETDD_BASE, 32'h0000_2000, ETDD_OKAY);
        axi_write(ETDD_CTRL, 32'h0400_420F, ETDD_OKAY);
        axi_read(ETDD_STATUS, d, r);
        check("pending", 32'(d[1]), 32'd1);
        run_event(32'h0000_1800, 1, 1'b0, 8);
        pulse(1'b1);
        for (int k = 0; k < 5; k++) begin
            run_event(32'h0000_2000 + 32'(k) * 32'h0000_0800, k, 1'b1, 16);
        end
        final_report();
    end
endmodule // testbench
`default_nettype wire
